/* File: logic/nvs_sequencer.sv */
// Page command sequencer: AXI4-Lite registers, store path, command engine.
// Assumes the core stalls on cpu_stall and the arrays answer on arr_done.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.

// Overview of operation
// - Array loads stall while operation runs
// - One page buffer shared by all memories
// - Stores land in buffer by low address
// - Store ANDs new and old buffer byte
// - Buffer all ones after reset, ops, wake
// - Page write copies buffer, flash stalls core
// - EEPROM touches only marked bytes
// - Page erase needs a marked byte
// - EEPROM page erase leaves core running
// - Erase-and-write: erase, program, then clear
// - Buffer clear halts core seven cycles
// - Chip erase spares EEPROM if preserve fuse
// - Chip erase ignores boot lock, write protect
// - EEPROM erase halts core until done
// - Fuse write only from debug port
// - Power-on lockout: busy flags read one
// - Lockout skipped by fuse settings
// - Reset aborts array write in progress
// - Interrupt while enabled and flag set
// - Pending write keeps clock running in sleep
// - Ready interrupt wakes from idle only
// - Three-bit command decode zero to seven
// - Status bits: flash, eeprom busy, error
// - Ready flag set while idle, write-one clears only while busy
module nvs_sequencer
	import nvs_pkg::*;
#(
	parameter int LOCKOUT_CYC = NVS_LOCKOUT_CYC
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        por_event,
	input  wire logic        from_debug_port,
	input  wire logic        fuse_timeout_disable,
	input  wire logic        fuse_reset_pin_debug,
	input  wire logic        fuse_eeprom_preserve,
	input  wire logic        boot_read_lock,
	input  wire logic        app_code_write_protect,
	input  wire logic        sys_sleep,
	input  wire logic        sys_sleep_idle,
	input  wire logic        sys_wake,
	input  wire logic        array_load_req,
	input  wire logic        arr_done,
	output nvs_array_s       arr_op,
	output logic [7:0]       arr_wdata,
	output logic [NVS_PAGE_AW-1:0] arr_idx,
	output logic             cpu_stall,
	output logic             clock_hold,
	output logic             irq,
	output logic             irq_wake
);

	typedef enum logic [2:0] {
		NVS_IDLE  = 3'b000,
		NVS_ERASE = 3'b001,
		NVS_PROG  = 3'b010,
		NVS_CLR   = 3'b011,
		NVS_WHOLE = 3'b100
	} nvs_state_e;

	nvs_state_e  state_q;
	nvs_cmd_e    cmd_q;
	logic        ee_q, flash_busy_flag_q, eeprom_busy_flag_q, wrerr_q, lock_q;
	logic        ie_q, ready_q, aw_q, w_q;
	logic [7:0]  awaddr_q, key_q;
	logic [31:0] wdata_q;
	logic [2:0]  key_cnt_q;
	logic [2:0]  clr_cnt_q;
	logic [31:0] lock_cnt_q;
	logic [15:0] addr_q, data_q, fuse_q;
	logic        por_m_q, por_q, wake_m_q, wake_q;
	logic        wr_fire, buf_clear, key_ok, cmd_wr;
	logic        any_mark;
	logic [NVS_PAGE_BYTES-1:0] mark;
	nvs_store_s  store;
	nvs_cmd_e    new_cmd;

	// Address classifier used by the command engine
	function automatic logic is_eeprom(input logic [15:0] a);
		return a >= NVS_EE_BASE && a < NVS_EE_LIMIT;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_m_q  <= 1'b0;
			por_q    <= 1'b0;
			wake_m_q <= 1'b0;
			wake_q   <= 1'b0;
		end else begin
			por_m_q  <= por_event;
			por_q    <= por_m_q;
			wake_m_q <= sys_wake;
			wake_q   <= wake_m_q;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	assign s_axi_bresp   = 2'h0;
	assign wr_fire       = aw_q && w_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q         <= 1'b0;
			w_q          <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'hffff_ffff;
			end
			if (wr_fire) begin
				aw_q         <= 1'b0;
				w_q          <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Protection key window and command acceptance
	// ----------------------------------------------------------------
	assign key_ok  = key_cnt_q != 3'h0;
	assign new_cmd = nvs_cmd_e'(wdata_q[2:0]);
	assign cmd_wr  = wr_fire && awaddr_q == NVS_CMD_CTRL_OFS && key_ok &&
		state_q == NVS_IDLE && !lock_q && new_cmd != NVS_CMD_NONE &&
		(new_cmd != NVS_CMD_FUSE || from_debug_port);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_cnt_q <= 3'h0;
		end else if (wr_fire && awaddr_q == NVS_KEY_OFS &&
				wdata_q[7:0] == NVS_SPM_KEY) begin
			key_cnt_q <= NVS_KEY_WINDOW;
		end else if (wr_fire && awaddr_q == NVS_CMD_CTRL_OFS) begin
			key_cnt_q <= 3'h0;
		end else if (wr_fire && key_ok) begin
			key_cnt_q <= key_cnt_q - 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// Power-on lockout
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_q     <= 1'b0;
			lock_cnt_q <= 32'h0000_0000;
		end else if (por_q && fuse_timeout_disable && !fuse_reset_pin_debug) begin
			lock_q     <= 1'b1;
			lock_cnt_q <= 32'(LOCKOUT_CYC);
		end else if (lock_cnt_q > 32'h1) begin
			lock_cnt_q <= lock_cnt_q - 32'h1;
		end else begin
			lock_q     <= 1'b0;
			lock_cnt_q <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Store path into the shared buffer
	// ----------------------------------------------------------------
	always_comb begin
		store.req  = wr_fire && (awaddr_q & NVS_BUF_MASK) == NVS_BUF_OFS &&
			!lock_q && state_q == NVS_IDLE;
		store.addr = {addr_q[15:NVS_PAGE_AW], awaddr_q[NVS_PAGE_AW+1:2]};
		store.data = wdata_q[7:0];
	end

	// Remember the target page from the most recent store
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_q <= 16'h0000;
			data_q <= 16'h0000;
			fuse_q <= 16'h0000;
		end else begin
			if (wr_fire && awaddr_q == NVS_ADDR_OFS)
				addr_q <= wdata_q[15:0];
			else if (store.req)
				addr_q <= store.addr;
			if (wr_fire && awaddr_q == NVS_DATA_OFS)
				data_q <= wdata_q[15:0];
			if (state_q == NVS_WHOLE && cmd_q == NVS_CMD_FUSE && arr_done)
				fuse_q <= data_q;
		end
	end

	assign buf_clear = wake_q ||
		(state_q == NVS_CLR && clr_cnt_q == 3'h1);

	nvs_page_buffer u_buf (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.store    (store),
		.clear    (buf_clear),
		.rd_idx   (arr_idx),
		.rd_data  (arr_wdata),
		.mark     (mark),
		.any_mark (any_mark)
	);

	// ----------------------------------------------------------------
	// Command engine
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= NVS_IDLE;
			cmd_q     <= NVS_CMD_NONE;
			ee_q      <= 1'b0;
			clr_cnt_q <= 3'h0;
			wrerr_q   <= 1'b0;
		end else begin
			unique case (state_q)
				NVS_IDLE: begin
					if (cmd_wr) begin
						cmd_q   <= new_cmd;
						ee_q    <= is_eeprom(addr_q);
						wrerr_q <= 1'b0;
						unique case (new_cmd)
							NVS_CMD_WRITE: state_q <= NVS_PROG;
							NVS_CMD_ERASE, NVS_CMD_ERWR: begin
								if (any_mark)
									state_q <= NVS_ERASE;
								else
									wrerr_q <= 1'b1;
							end
							NVS_CMD_CLEAR: begin
								state_q   <= NVS_CLR;
								clr_cnt_q <= 3'(NVS_CLR_CYC);
							end
							default: state_q <= NVS_WHOLE;
						endcase
					end else if (wr_fire && awaddr_q == NVS_CMD_CTRL_OFS) begin
						wrerr_q <= 1'b1;
					end
				end
				NVS_ERASE: if (arr_done)
					state_q <= (cmd_q == NVS_CMD_ERWR) ? NVS_PROG : NVS_CLR;
				NVS_PROG, NVS_WHOLE: if (arr_done) begin
					state_q   <= NVS_CLR;
					clr_cnt_q <= 3'(NVS_CLR_CYC);
				end
				NVS_CLR: begin
					clr_cnt_q <= clr_cnt_q - 3'h1;
					if (clr_cnt_q == 3'h1)
						state_q <= NVS_IDLE;
				end
				default: state_q <= NVS_IDLE;
			endcase
			if (state_q == NVS_ERASE && arr_done && cmd_q != NVS_CMD_ERWR)
				clr_cnt_q <= 3'(NVS_CLR_CYC);
		end
	end

	// Array request: marks given for EEPROM, chip erase ignores locks
	always_comb begin
		arr_op.start = (state_q == NVS_ERASE || state_q == NVS_PROG ||
			state_q == NVS_WHOLE) && !arr_done;
		arr_op.cmd   = (state_q == NVS_ERASE) ? NVS_CMD_ERASE :
			(state_q == NVS_PROG) ? NVS_CMD_WRITE : cmd_q;
		arr_op.ee    = (cmd_q == NVS_CMD_CHIP) ? !fuse_eeprom_preserve : ee_q;
		arr_op.addr  = addr_q;
		arr_op.mark  = ee_q ? mark : '1;
	end
	assign arr_idx = addr_q[NVS_PAGE_AW-1:0];

	// ----------------------------------------------------------------
	// Busy flags, stall, ready flag, interrupt, sleep
	// ----------------------------------------------------------------
	always_comb begin
		flash_busy_flag_q  = lock_q || (state_q != NVS_IDLE &&
			(!ee_q || cmd_q == NVS_CMD_CHIP || cmd_q == NVS_CMD_CLEAR));
		eeprom_busy_flag_q = lock_q || (state_q != NVS_IDLE && ee_q);
	end

	assign cpu_stall = (array_load_req && state_q != NVS_IDLE) ||
		(state_q != NVS_IDLE && (!ee_q || cmd_q == NVS_CMD_EEALL ||
			cmd_q == NVS_CMD_CLEAR));
	assign clock_hold = sys_sleep && state_q != NVS_IDLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ready_q <= 1'b0;
			ie_q    <= 1'b0;
		end else begin
			if (wr_fire && awaddr_q == NVS_INT_EN_OFS)
				ie_q <= wdata_q[0];
			if (!eeprom_busy_flag_q && state_q == NVS_IDLE)
				ready_q <= 1'b1;
			else if (wr_fire && awaddr_q == NVS_INT_FLAG_OFS && wdata_q[0])
				ready_q <= 1'b0;
		end
	end

	assign irq      = ie_q && ready_q;
	assign irq_wake = irq && sys_sleep_idle;

	// ----------------------------------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp   = 2'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			unique case (s_axi_araddr)
				NVS_CMD_CTRL_OFS: s_axi_rdata <= {29'h0, cmd_q};
				NVS_PROT_OFS:     s_axi_rdata <= {30'h0, boot_read_lock,
					app_code_write_protect};
				NVS_STATUS_OFS:   s_axi_rdata <= {29'h0, wrerr_q, eeprom_busy_flag_q,
					flash_busy_flag_q};
				NVS_INT_EN_OFS:   s_axi_rdata <= {31'h0, ie_q};
				NVS_INT_FLAG_OFS: s_axi_rdata <= {31'h0, ready_q};
				NVS_DATA_OFS:     s_axi_rdata <= {16'h0, data_q};
				NVS_ADDR_OFS:     s_axi_rdata <= {16'h0, addr_q};
				NVS_FUSE_OFS:     s_axi_rdata <= {16'h0, fuse_q};
				default:          s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_load_stall: assert property (@(posedge aclk) disable iff (!aresetn)
		array_load_req && state_q != NVS_IDLE |-> cpu_stall)
		else $error("array load not stalled during operation");
	a_clear_seven: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_wr && new_cmd == NVS_CMD_CLEAR |=> cpu_stall [*7] ##1 !flash_busy_flag_q)
		else $error("buffer clear did not halt for seven cycles");
	a_erase_needs: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_wr && new_cmd == NVS_CMD_ERASE && !any_mark |=> state_q == NVS_IDLE)
		else $error("page erase ran with empty buffer");
	a_fuse_port: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && awaddr_q == NVS_CMD_CTRL_OFS && new_cmd == NVS_CMD_FUSE &&
		state_q == NVS_IDLE && !from_debug_port |=> state_q == NVS_IDLE)
		else $error("fuse write accepted from core");
	a_lock_busy: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_q |-> flash_busy_flag_q && eeprom_busy_flag_q && !store.req && !cmd_wr)
		else $error("write allowed during lockout");
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		irq == (ie_q && ready_q))
		else $error("interrupt does not follow flag and enable");
	a_busy_accept: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_wr && !(new_cmd inside {NVS_CMD_ERASE, NVS_CMD_ERWR})
		|=> flash_busy_flag_q || eeprom_busy_flag_q)
		else $error("busy not raised after accepted command");
	a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		sys_sleep && state_q != NVS_IDLE |-> clock_hold)
		else $error("clock released during pending write");
	a_erwr_order: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == NVS_ERASE && cmd_q == NVS_CMD_ERWR && arr_done
		|=> state_q == NVS_PROG)
		else $error("erase-and-write skipped program step");
	c_clear: cover property (@(posedge aclk) cmd_wr && new_cmd == NVS_CMD_CLEAR);
	c_erwr: cover property (@(posedge aclk) state_q == NVS_PROG && cmd_q == NVS_CMD_ERWR);
	c_irq: cover property (@(posedge aclk) irq);

endmodule

/* File: logic/nvs_pkg.sv */
// Package for the page command sequencer: register map, fields, timing.
// Assumes a 50 MHz aclk and an AXI4-Lite master on the register side.
package nvs_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned word each except the buffer window 0x80-0xff)
	// ----------------------------------------------------------------
	localparam logic [7:0] NVS_CMD_CTRL_OFS  = 8'h00;
	localparam logic [7:0] NVS_PROT_OFS      = 8'h04;
	localparam logic [7:0] NVS_STATUS_OFS    = 8'h08;
	localparam logic [7:0] NVS_INT_EN_OFS    = 8'h0c;
	localparam logic [7:0] NVS_INT_FLAG_OFS  = 8'h10;
	localparam logic [7:0] NVS_DATA_OFS      = 8'h18;
	localparam logic [7:0] NVS_ADDR_OFS      = 8'h20;
	localparam logic [7:0] NVS_KEY_OFS       = 8'h24;
	localparam logic [7:0] NVS_FUSE_OFS      = 8'h28;
	localparam logic [7:0] NVS_BUF_OFS       = 8'h80;
	localparam logic [7:0] NVS_BUF_MASK      = 8'h80;

	// ----------------------------------------------------------------
	// Fields and constants
	// ----------------------------------------------------------------
	localparam int         NVS_ST_FLASH_BUSY_FLAG      = 0;
	localparam int         NVS_ST_EEPROM_BUSY_FLAG     = 1;
	localparam int         NVS_ST_WRERR      = 2;
	localparam logic [7:0] NVS_SPM_KEY       = 8'h9d;
	localparam logic [2:0] NVS_KEY_WINDOW    = 3'h4;
	localparam int         NVS_PAGE_BYTES    = 32;
	localparam int         NVS_PAGE_AW       = 5;
	localparam logic [15:0] NVS_EE_BASE      = 16'h1400;
	localparam logic [15:0] NVS_EE_LIMIT     = 16'h1600;
	localparam logic [1:0] NVS_FUSE_TOUT_BIT = 2'h0;
	localparam logic [7:0] NVS_BUF_RESET     = 8'hff;

	// ----------------------------------------------------------------
	// Timing (ns, then cycles at 50 MHz)
	// ----------------------------------------------------------------
	localparam int NVS_CLK_NS       = 20;
	localparam int NVS_CLR_CYC      = 7;
	localparam int NVS_ARRAY_OP_NS  = 400;
	localparam int NVS_ARRAY_CYC    = (NVS_ARRAY_OP_NS + NVS_CLK_NS - 1)
		/ NVS_CLK_NS;
	localparam int NVS_LOCKOUT_NS   = 200000;
	localparam int NVS_LOCKOUT_CYC  = NVS_LOCKOUT_NS / NVS_CLK_NS;

	typedef enum logic [2:0] {
		NVS_CMD_NONE  = 3'h0,
		NVS_CMD_WRITE = 3'h1,
		NVS_CMD_ERASE = 3'h2,
		NVS_CMD_ERWR  = 3'h3,
		NVS_CMD_CLEAR = 3'h4,
		NVS_CMD_CHIP  = 3'h5,
		NVS_CMD_EEALL = 3'h6,
		NVS_CMD_FUSE  = 3'h7
	} nvs_cmd_e;

	typedef struct packed {
		logic        req;
		logic [15:0] addr;
		logic [7:0]  data;
	} nvs_store_s;

	typedef struct packed {
		logic                     start;
		nvs_cmd_e                 cmd;
		logic                     ee;
		logic [15:0]              addr;
		logic [NVS_PAGE_BYTES-1:0] mark;
	} nvs_array_s;

endpackage

/* File: logic/nvs_page_buffer.sv */
// Shared page buffer with AND-merge stores and per-byte mark bits.
// Assumes one store or one clear per cycle from the sequencer.
module nvs_page_buffer
	import nvs_pkg::*;
(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire nvs_store_s                store,
	input  wire logic                      clear,
	input  wire logic [NVS_PAGE_AW-1:0]    rd_idx,
	output logic      [7:0]                rd_data,
	output logic      [NVS_PAGE_BYTES-1:0] mark,
	output logic                           any_mark
);

	logic [7:0] buf_q [NVS_PAGE_BYTES];
	logic [NVS_PAGE_BYTES-1:0] mark_q;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NVS_PAGE_BYTES; gi++) begin : g_byte
			always_ff @(posedge aclk) begin
				if (!aresetn || clear) begin
					buf_q[gi] <= NVS_BUF_RESET;
					mark_q[gi] <= 1'b0;
				end else if (store.req &&
						store.addr[NVS_PAGE_AW-1:0] == NVS_PAGE_AW'(gi)) begin
					buf_q[gi] <= buf_q[gi] & store.data;
					mark_q[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	assign rd_data  = buf_q[rd_idx];
	assign mark     = mark_q;
	assign any_mark = |mark_q;

	a_and_merge: assert property (@(posedge aclk) disable iff (!aresetn)
		store.req && !clear |=> buf_q[$past(store.addr[NVS_PAGE_AW-1:0])] ==
			($past(buf_q[store.addr[NVS_PAGE_AW-1:0]]) & $past(store.data)))
		else $error("page buffer store did not AND-merge");
	a_clear_ones: assert property (@(posedge aclk) disable iff (!aresetn)
		clear |=> buf_q[0] == NVS_BUF_RESET && mark_q == '0)
		else $error("page buffer not all ones after clear");

endmodule

/* File: tb/nvs_array_model.sv */
// Array partner: answers each started operation with a done pulse.
// Assumes arr_op.start may stay high until the answer is given.
module nvs_array_model
	import nvs_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire nvs_array_s arr_op,
	input  wire logic       slow,
	output logic            arr_done,
	output nvs_array_s      last_op,
	output int              n_start
);
	timeunit 1ns;
	timeprecision 1ps;
	int wait_q;
	// Slow answers leave room to poke the core mid-operation
	always @(posedge aclk) begin
		arr_done <= 1'b0;
		if (!aresetn) begin
			wait_q <= 0;
			n_start <= 0;
		end else if (arr_op.start && wait_q == 0) begin
			last_op <= arr_op;
			n_start <= n_start + 1;
			wait_q <= slow ? 12 : 2;
		end else if (wait_q == 1) begin
			arr_done <= 1'b1;
			wait_q <= 0;
		end else if (wait_q != 0) begin
			wait_q <= wait_q - 1;
		end
	end
endmodule

/* File: tb/test_nvs_sequencer.sv */
// Self-checking bench for the page command sequencer.
// Assumes the sequencer and the array partner model are compiled first.
module test_nvs_sequencer
	import nvs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0, aresetn = 0, por_event = 1, from_debug_port = 0;
	logic fuse_timeout_disable = 1, fuse_reset_pin_debug = 0;
	logic fuse_eeprom_preserve = 0, boot_read_lock = 0, slow = 0;
	logic app_code_write_protect = 0, sys_sleep = 0, sys_sleep_idle = 0;
	logic sys_wake = 0, array_load_req = 0, arr_done, cpu_stall;
	logic irq, irq_wake, clock_hold;
	logic [7:0] arr_wdata;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, r, a, b;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	nvs_array_s arr_op, last_op;
	logic stall_op = 0;
	int n_fail = 0, checks = 0, run = 0, last_run = 0, cyc = 0, n_start, n;
	nvs_cmd_e tbl[5] = '{NVS_CMD_WRITE, NVS_CMD_ERASE, NVS_CMD_ERWR,
		NVS_CMD_CHIP, NVS_CMD_EEALL};

	nvs_sequencer #(.LOCKOUT_CYC(20)) nvs_sequencer_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .por_event, .from_debug_port,
		.fuse_timeout_disable, .fuse_reset_pin_debug, .fuse_eeprom_preserve,
		.boot_read_lock, .app_code_write_protect, .sys_sleep,
		.sys_sleep_idle, .sys_wake, .array_load_req, .arr_done, .arr_op,
		.arr_wdata, .arr_idx(), .cpu_stall, .clock_hold, .irq,
		.irq_wake);
	nvs_array_model nvs_array_model_inst (.aclk, .aresetn, .arr_op, .slow,
		.arr_done, .last_op, .n_start);

	always #10 aclk = ~aclk;

	// ----------------------------------------------------------------
	// Monitors and closing
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (cpu_stall === 1'b1) run <= run + 1;
		else if (run != 0) begin
			last_run <= run;
			run <= 0;
		end
		if (cpu_stall === 1'b1 && nvs_array_model_inst.wait_q != 0)
			stall_op <= 1'b1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic final_report();
		if (n_fail == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic st(input int k, input logic [7:0] v);
		wr(NVS_BUF_OFS + 8'(4 * k), {24'h0, v});
	endtask

	// The buffer is write-only on the bus; it is seen through the array port
	task automatic rb(input int k);
		wr(NVS_ADDR_OFS, 32'(k));
		r = {24'h0, arr_wdata};
	endtask

	task automatic go(input nvs_cmd_e c);
		stall_op <= 1'b0;
		wr(NVS_KEY_OFS, {24'h0, NVS_SPM_KEY});
		wr(NVS_CMD_CTRL_OFS, {29'h0, c});
	endtask

	task automatic idle();
		do rd(NVS_STATUS_OFS, r);
		while (r[1:0] !== 2'b00);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hf2a9));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// Power-on level must outlast reset to pass the synchroniser
		repeat (4) @(posedge aclk);
		por_event <= 1'b0;
		rd(NVS_STATUS_OFS, r);
		chk("lockout busy", 32'h3, r & 32'h3);
		st(0, 8'h00);
		idle();
		rb(0);
		chk("locked store", 32'hff, r);
		for (int i = 0; i < 4; i++) begin
			n = i * 8 + $urandom_range(7);
			a = $urandom;
			b = $urandom;
			st(n, a[7:0]);
			st(n, b[7:0]);
			rb(n);
			chk("merged byte", {24'h0, a[7:0] & b[7:0]}, r);
		end
		go(NVS_CMD_CLEAR);
		idle();
		chk("clear stall", 32'd7, 32'(last_run));
		rb(n);
		chk("cleared byte", 32'hff, r);
		wr(NVS_CMD_CTRL_OFS, {29'h0, NVS_CMD_CLEAR});
		rd(NVS_STATUS_OFS, r);
		chk("no key error", 32'h1, {31'h0, r[2]});
		go(NVS_CMD_CLEAR);
		idle();
		chk("error after ok", 32'h0, {31'h0, r[2]});
		go(NVS_CMD_FUSE);
		rd(NVS_STATUS_OFS, r);
		chk("core fuse cmd", 32'h1, {31'h0, r[2]});
		n = n_start;
		go(NVS_CMD_ERASE);
		idle();
		chk("empty erase", 32'(n), 32'(n_start));
		wr(NVS_ADDR_OFS, 32'h0200);
		st(0, 8'hff);
		go(NVS_CMD_ERASE);
		idle();
		for (int j = 0; j < 5; j++) begin
			wr(NVS_ADDR_OFS, j[0] ? NVS_EE_BASE : 16'h0200);
			st(j, 8'($urandom));
			st(j + 5, 8'($urandom));
			fuse_eeprom_preserve <= 1'($urandom);
			boot_read_lock <= 1'($urandom);
			app_code_write_protect <= 1'($urandom);
			go(tbl[j]);
			idle();
			chk("op code", {29'h0, (j == 2) ? NVS_CMD_WRITE : tbl[j]},
				{29'h0, last_op.cmd});
			if (j == 3) chk("chip ee", {31'h0, !fuse_eeprom_preserve},
				{31'h0, last_op.ee});
			if (j == 1) chk("ee marks", 32'h42, last_op.mark);
			if (j != 3) chk("core stall", (j == 4) ? 1 : !j[0], stall_op);
			rb(j);
			chk("buffer after op", 32'hff, r);
		end
		slow <= 1'b1;
		wr(NVS_INT_EN_OFS, 32'h1);
		chk("ready irq", 32'h1, {31'h0, irq});
		wr(NVS_ADDR_OFS, NVS_EE_BASE);
		st(2, 8'h5a);
		go(NVS_CMD_WRITE);
		array_load_req <= 1'b1;
		sys_sleep <= 1'b1;
		sys_sleep_idle <= 1'b1;
		@(posedge aclk);
		#1 chk("load stall", 32'h1, {31'h0, cpu_stall});
		chk("sleep hold", 32'h1, {31'h0, clock_hold});
		array_load_req <= 1'b0;
		wr(NVS_INT_FLAG_OFS, 32'h1);
		chk("flag cleared", 32'h0, {31'h0, irq});
		idle();
		repeat (2) @(posedge aclk);
		chk("idle wake", 32'h1, {31'h0, irq_wake});
		sys_sleep <= 1'b0;
		st(0, 8'h00);
		sys_wake <= 1'b1;
		repeat (3) @(posedge aclk);
		sys_wake <= 1'b0;
		n = 0;
		do begin
			rb(0);
			n++;
		end while (r !== 32'hff && n < 8);
		chk("wake clear", 32'hff, r);
		rd(8'h30, r);
		chk("unmapped resp", 32'h0, {30'h0, resp});
		final_report();
	end
endmodule
